// [logic/l2m_consts.svh]
// Notes on behaviour
// - data-only: new instruction misses bypass, hits allowed
// - both only bits: locked, no allocation, hits write
// - instruction-only: data hits served, misses bypass
// - instruction-only bit changeable anytime, next transaction
// - global invalidate clears every line state
// - low-power control drives sram sleep in nap/sleep
// - write-through forwards writes to bus; default back
// - write-through store marks line exclusive, not modified
// - test-support: flush/store pushes stay in l2 valid
// - test-support: suppress zero-block broadcast, single-beat store misses
// - two-bit output hold field, program 00
// - dll slow bit lengthens taps, keep zero
// - differential clock bit for late-write, keep zero
// - reserved bits stored, no effect
// - whole control register cleared by reset
// - enable starts operation at next transaction
`ifndef L2M_CONSTS_SVH
`define L2M_CONSTS_SVH
// register byte address
`define L2M_CTRL_ADDR 12'h000
`define L2M_STAT_ADDR 12'h004
`define L2M_CTRL_RESET 32'h0000_0000
// field bit positions, bit 0 is the least significant bit of the word
`define L2M_BIT_ENABLE 31
`define L2M_BIT_DO 22
`define L2M_BIT_INV 21
`define L2M_BIT_CTL 20
`define L2M_BIT_WT 19
`define L2M_BIT_TS 18
`define L2M_BIT_OH_HI 17
`define L2M_BIT_OH_LO 16
`define L2M_BIT_SL 15
`define L2M_BIT_DF 14
`define L2M_BIT_BYP 13
`define L2M_BIT_RSV_HI 12
`define L2M_BIT_RSV_LO 11
`define L2M_BIT_IO 10
// mask of bits held by this block (bits 31 and 10..22)
`define L2M_CTRL_MASK 32'h807F_FC00
`endif

// [logic/l2m_pkg.sv]
package l2m_pkg;
  // transaction request from the l1 side
  typedef struct packed {
    logic valid;
    logic is_instr;   // instruction fetch, else data
    logic is_write;   // store
    logic hit;        // tag lookup result
    logic is_push;    // flush/store-block push
    logic is_zero;    // zero-block operation
    logic single_beat;
  } l2m_req_t;
  // routing decision for the transaction
  typedef struct packed {
    logic valid;
    logic use_l2;      // service from/to l2
    logic allocate;    // allocate a new line on miss
    logic to_bus;      // forward to system bus
    logic mark_excl;   // new line state exclusive
    logic mark_mod;    // new line state modified
    logic mark_inval;  // invalidate l2 copy
    logic inhibited;   // passed as cache-inhibited
  } l2m_resp_t;
  // power mode of the core
  typedef enum logic [1:0] {L2M_RUN, L2M_NAP, L2M_SLEEP} l2m_pwr_t;
endpackage : l2m_pkg

// [logic/l2m_ctrl.sv]
`include "l2m_consts.svh"
module l2m_ctrl #(
  parameter int NUM_LINES = 16   // lines whose state bits are held here
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire l2m_pkg::l2m_req_t req,
  input wire l2m_pkg::l2m_pwr_t pwr_mode,
  output l2m_pkg::l2m_resp_t resp,
  output logic sram_sleep_output,
  output logic [1:0] output_hold_field,
  output logic dll_slow_select,
  output logic differential_clock_select,
  output logic cache_enable_bit,
  output logic invalidate_busy
);
  import l2m_pkg::*;

  // control word, only mapped bits stored
  logic [31:0] ctrl_q;
  // per-line valid/status state
  logic [NUM_LINES-1:0] line_valid_q;
  logic [NUM_LINES-1:0] line_mod_q;
  // invalidation in progress
  logic inv_q;
  // allocation pointer, one slot per allocating transaction
  logic [$clog2(NUM_LINES)-1:0] slot_q;
  // combinational routing decision, registered into resp
  l2m_resp_t resp_d;

  // decoded mode bits, read by the routing and sram sleep logic
  logic data_only_select;
  logic instruction_only_select;
  logic write_through_select;
  logic test_support_select;
  logic ram_low_power_control;
  // apb phase decode
  logic setup;
  logic access;

  assign data_only_select = ctrl_q[`L2M_BIT_DO];
  assign instruction_only_select = ctrl_q[`L2M_BIT_IO];
  assign write_through_select = ctrl_q[`L2M_BIT_WT];
  assign test_support_select = ctrl_q[`L2M_BIT_TS];
  assign ram_low_power_control = ctrl_q[`L2M_BIT_CTL];
  assign setup = psel && !penable;
  assign access = psel && penable;

  // address decode used only for the error response
  function automatic logic is_mapped(input logic [11:0] a);
    is_mapped = (a == `L2M_CTRL_ADDR) || (a == `L2M_STAT_ADDR);
  endfunction : is_mapped

  // apb handshake: no wait states, ready rises in the access phase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      // unmapped addresses are refused in the same cycle as ready
      pready <= setup;
      pslverr <= setup && !is_mapped(paddr);
    end
  end

  // read data registered in setup so it stands with pready
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      // nothing to show before the first read
      prdata <= 32'h0000_0000;
    end
    else if (setup && !pwrite)
    begin
      if (paddr == `L2M_CTRL_ADDR)
      begin
        // stored fields; invalidate bit reads back as written
        prdata <= ctrl_q;
      end
      else if (paddr == `L2M_STAT_ADDR)
      begin
        // busy flag and count of valid lines
        prdata <= {inv_q, 15'h0000, 16'(count_ones(line_valid_q))};
      end
      else
      begin
        prdata <= 32'h0000_0000;
      end
    end
  end

  // count of valid lines for status
  function automatic int count_ones(input logic [NUM_LINES-1:0] v);
    // plain loop; fine for the small line counts modelled here
    count_ones = 0;
    for (int i = 0; i < NUM_LINES; i++)
    begin
      count_ones = count_ones + int'(v[i]);
    end
  endfunction : count_ones

  // control register write, taken at the completing access edge
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      // hard or power-on reset clears every field
      ctrl_q <= `L2M_CTRL_RESET;
    end
    else if (access && pready && pwrite && paddr == `L2M_CTRL_ADDR)
    begin
      // mode and reserved bits just stored; instruction-only may change any time
      ctrl_q <= pwdata & `L2M_CTRL_MASK;
    end
  end

  // global invalidate: one cycle after the request lands, all lines cleared
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      inv_q <= 1'b0;
    end
    else
    begin
      // single pulse per request; stays low once the lines are empty
      inv_q <= ctrl_q[`L2M_BIT_INV] && !inv_q && line_valid_q != '0;
    end
  end

  // line state: invalidation wins over any allocation in the same cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      // no line valid after reset
      line_valid_q <= '0;
      line_mod_q <= '0;
    end
    else if (ctrl_q[`L2M_BIT_INV])
    begin
      // software is expected to have cleared enable first
      line_valid_q <= '0;
      line_mod_q <= '0;
    end
    else if (resp_d.valid && !resp_d.inhibited)
    begin
      // single line slot chosen by a running pointer; enough for status
      if (resp_d.allocate || resp_d.mark_inval || resp_d.mark_excl || resp_d.mark_mod)
      begin
        line_valid_q[slot_q] <= !resp_d.mark_inval;
        line_mod_q[slot_q] <= resp_d.mark_mod;
      end
    end
  end

  // slot pointer for allocations, wraps so the oldest slot is reused first
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      slot_q <= '0;
    end
    else if (resp_d.valid && resp_d.allocate)
    begin
      slot_q <= slot_q + 1'b1;
    end
  end

  // routing decision for the incoming transaction; priority order matters:
  // disabled first, then the only-bit bypass, so a locked cache never allocates
  always_comb
  begin
    resp_d = '0;
    resp_d.valid = req.valid;
    if (!req.valid)
    begin
      // idle
    end
    else if (!ctrl_q[`L2M_BIT_ENABLE])
    begin
      // disabled cache: everything goes straight through
      resp_d.to_bus = 1'b1;
      resp_d.inhibited = 1'b1;
    end
    else if (!req.hit && ((req.is_instr && data_only_select) || (!req.is_instr && instruction_only_select)))
    begin
      // new miss of the excluded kind bypasses, no lookup effect; locked when both set
      resp_d.to_bus = 1'b1;
      resp_d.inhibited = 1'b1;
    end
    else if (req.is_push && test_support_select)
    begin
      // pushes kept in l2, marked valid
      resp_d.use_l2 = 1'b1;
      resp_d.mark_excl = !req.hit || !line_mod_any();
      resp_d.allocate = !req.hit;
    end
    else if (req.is_push)
    begin
      // normal push: to bus, l2 copy dropped on hit
      resp_d.to_bus = 1'b1;
      resp_d.mark_inval = req.hit;
    end
    else if (req.is_zero && test_support_select)
    begin
      // zero-block kept local, no broadcast
      resp_d.use_l2 = 1'b1;
      resp_d.allocate = !req.hit;
      resp_d.mark_mod = !write_through_select;
      resp_d.mark_excl = write_through_select;
    end
    else if (req.is_write && !req.hit && req.single_beat && test_support_select)
    begin
      // single-beat store miss held out of the bus
      resp_d.use_l2 = 1'b1;
    end
    else if (req.is_write)
    begin
      // hits update in place; write-through forwards and keeps exclusive
      resp_d.use_l2 = 1'b1;
      resp_d.allocate = !req.hit && !req.single_beat;
      resp_d.to_bus = write_through_select || (!req.hit && req.single_beat);
      resp_d.mark_excl = write_through_select;
      resp_d.mark_mod = !write_through_select;
    end
    else
    begin
      // reads: hit served, miss fetched from bus and allocated
      resp_d.use_l2 = 1'b1;
      resp_d.to_bus = !req.hit;
      resp_d.allocate = !req.hit;
      resp_d.mark_excl = !req.hit;
    end
  end

  // any modified line present, keeps push marking honest
  function automatic logic line_mod_any();
    line_mod_any = line_mod_q != '0;
  endfunction : line_mod_any

  // registered decision; one cycle from request to response
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      resp <= '0;
    end
    else
    begin
      // stands for exactly one cycle per request
      resp <= resp_d;
    end
  end

  // sram sleep follows nap/sleep while low-power control is set
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sram_sleep_output <= 1'b0;
    end
    else
    begin
      // no filtering: the pin follows the power mode edge by edge
      sram_sleep_output <= ram_low_power_control && (pwr_mode != L2M_RUN);
    end
  end

  // output hold code straight to the sram pads; only 00 is meant for this part
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      output_hold_field <= 2'h0;
    end
    else
    begin
      output_hold_field <= ctrl_q[`L2M_BIT_OH_HI:`L2M_BIT_OH_LO];
    end
  end

  // dll tap stretch; nothing here checks the bus speed, software must
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dll_slow_select <= 1'b0;
    end
    else
    begin
      dll_slow_select <= ctrl_q[`L2M_BIT_SL];
    end
  end

  // differential clock scheme select for late-write parts
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      differential_clock_select <= 1'b0;
    end
    else
    begin
      differential_clock_select <= ctrl_q[`L2M_BIT_DF];
    end
  end

  // enable pin; the routing reads ctrl_q directly, so this copy lags one cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cache_enable_bit <= 1'b0;
    end
    else
    begin
      cache_enable_bit <= ctrl_q[`L2M_BIT_ENABLE];
    end
  end

  // busy flag for the outside, one cycle behind the internal pulse
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      invalidate_busy <= 1'b0;
    end
    else
    begin
      invalidate_busy <= inv_q;
    end
  end
endmodule : l2m_ctrl

// [sim/l2m_l1_model.sv]
module l2m_l1_model
(
  input wire logic pclk,
  output l2m_pkg::l2m_req_t req
);
  timeunit 1ns;
  timeprecision 1ns;
  import l2m_pkg::*;
  initial req = '0;
  // one transaction per call; afterwards valid drops and the other fields flip so stale values never pass for live ones
  task automatic send(input l2m_req_t r);
    @(posedge pclk);
    req <= r;
    @(posedge pclk);
    req <= ~r & 7'h3F;
  endtask : send
endmodule : l2m_l1_model

// [sim/l2m_ctrl_checker.sv]
`include "l2m_consts.svh"
module l2m_ctrl_checker
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire l2m_pkg::l2m_req_t req,
  input wire l2m_pkg::l2m_pwr_t pwr_mode,
  input wire l2m_pkg::l2m_resp_t resp,
  input wire logic sram_sleep_output,
  input wire logic [1:0] output_hold_field,
  input wire logic dll_slow_select,
  input wire logic differential_clock_select,
  input wire logic cache_enable_bit
);
  timeunit 1ns;
  timeprecision 1ns;
  import l2m_pkg::*;
  logic [31:0] sh_q; // shadow of the control word
  logic en; // shadow enable
  assign en = sh_q[`L2M_BIT_ENABLE];
  // shadow follows accepted writes only, refused ones are ignored
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      sh_q <= 32'h0000_0000;
    else if (psel && penable && pready && pwrite && !pslverr && paddr == `L2M_CTRL_ADDR)
      sh_q <= pwdata & `L2M_CTRL_MASK;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_hold; sh_q == $past(sh_q) |-> output_hold_field == sh_q[17:16]; endproperty
  a_hold: assert property (p_hold) else $error("hold field wrong");
  property p_slow; sh_q == $past(sh_q) |-> dll_slow_select == sh_q[`L2M_BIT_SL]; endproperty
  a_slow: assert property (p_slow) else $error("slow bit wrong");
  property p_diff; sh_q == $past(sh_q) |-> differential_clock_select == sh_q[`L2M_BIT_DF]; endproperty
  a_diff: assert property (p_diff) else $error("diff bit wrong");
  property p_en; sh_q == $past(sh_q) |-> cache_enable_bit == en; endproperty
  a_en: assert property (p_en) else $error("enable wrong");
  // stable cause for two edges, then the pin must follow
  property p_sleep;
    (sh_q[`L2M_BIT_CTL] && pwr_mode != L2M_RUN) == $past(sh_q[`L2M_BIT_CTL] && pwr_mode != L2M_RUN)
      |-> sram_sleep_output == (sh_q[`L2M_BIT_CTL] && pwr_mode != L2M_RUN);
  endproperty
  a_sleep: assert property (p_sleep) else $error("sram sleep wrong");
  property p_do; en && sh_q[`L2M_BIT_DO] && req.valid && req.is_instr && !req.hit
    |=> resp.valid && resp.inhibited && !resp.use_l2 && !resp.allocate; endproperty
  a_do: assert property (p_do) else $error("instr miss not bypassed");
  property p_lock; en && sh_q[`L2M_BIT_DO] && sh_q[`L2M_BIT_IO] && req.valid && !req.hit |=> !resp.allocate;
  endproperty
  a_lock: assert property (p_lock) else $error("locked cache allocated");
  property p_wt; en && sh_q[`L2M_BIT_WT] && req.valid && req.is_write && req.hit
    |=> resp.to_bus && resp.mark_excl && !resp.mark_mod; endproperty
  a_wt: assert property (p_wt) else $error("write-through wrong");
  property p_ts; en && sh_q[`L2M_BIT_TS] && req.valid && req.is_push
    |=> resp.use_l2 && !resp.to_bus && !resp.mark_inval; endproperty
  a_ts: assert property (p_ts) else $error("push left l2");
  c_lock: cover property (en && sh_q[`L2M_BIT_DO] && sh_q[`L2M_BIT_IO] && req.valid);
  c_ts: cover property (en && sh_q[`L2M_BIT_TS] && req.valid);
  c_sleep: cover property (sram_sleep_output);
endmodule : l2m_ctrl_checker
bind l2m_ctrl l2m_ctrl_checker l2m_ctrl_checker_i (.*);

// [sim/l2m_bench.sv]
`include "l2m_consts.svh"
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin error_cnt++; $display("BAD %s exp %h got %h", n, e, g); end end
module l2_cache_mode_control_fields_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import l2m_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, er; // apb side
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  l2m_req_t req; // driven by the l1 model
  l2m_pwr_t pwr_mode = L2M_RUN;
  l2m_resp_t resp;
  logic sram_sleep_output, dll_slow_select, differential_clock_select, cache_enable_bit, invalidate_busy;
  logic [1:0] output_hold_field;
  int error_cnt = 0, n_checks = 0;
  always #5 pclk = ~pclk;
  l2m_ctrl l2m_ctrl_i (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .req(req),
    .pwr_mode(pwr_mode),
    .resp(resp),
    .sram_sleep_output(sram_sleep_output),
    .output_hold_field(output_hold_field),
    .dll_slow_select(dll_slow_select),
    .differential_clock_select(differential_clock_select),
    .cache_enable_bit(cache_enable_bit),
    .invalidate_busy(invalidate_busy)
  );
  l2m_l1_model l2m_l1_model_i (
    .pclk(pclk),
    .req(req)
  );
  // one apb transfer; no fixed latency assumed, bounded wait on pready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    // ready, data and error taken at the rising edge that completes the access
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (!pready && n < 20);
    rd = prdata;
    er = pslverr;
    if (n >= 20) `CHK("pready", 1'h1, 1'h0)
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb
  // cache disabled first so policy bits are only ever set in the same write that enables
  task automatic mode(input logic [31:0] c, input l2m_req_t r, input logic [7:0] m, input logic [7:0] e);
    apb(1'h1, `L2M_CTRL_ADDR, 32'h0000_0000);
    apb(1'h1, `L2M_CTRL_ADDR, c);
    l2m_l1_model_i.send(r);
    @(negedge pclk);
    `CHK("resp", e, resp & m)
  endtask : mode
  task automatic pw(input l2m_pwr_t p, input logic e);
    @(posedge pclk);
    pwr_mode <= p;
    repeat (3) @(negedge pclk);
    `CHK("sram sleep", e, sram_sleep_output)
  endtask : pw
  task automatic t_regs;
    apb(1'h0, `L2M_CTRL_ADDR, 32'h0000_0000);
    `CHK("ctrl reset", 32'h0000_0000, rd)
    apb(1'h1, 12'h008, 32'hFFFF_FFFF);
    `CHK("unmapped", 1'h1, er)
    apb(1'h1, `L2M_CTRL_ADDR, 32'h0007_F800);
    apb(1'h0, `L2M_CTRL_ADDR, 32'h0000_0000);
    `CHK("ctrl read", 32'h0007_F800, rd)
    `CHK("hold", 2'h3, output_hold_field)
    `CHK("slow", 1'h1, dll_slow_select)
    `CHK("diff", 1'h1, differential_clock_select)
    apb(1'h1, `L2M_CTRL_ADDR, 32'h0000_0000);
    repeat (2) @(negedge pclk);
    `CHK("hold zero", 2'h0, output_hold_field)
    $display("t_regs done");
  endtask : t_regs
  task automatic t_modes;
    mode(32'h0000_0000, 7'h40, 8'hD1, 8'h91);
    mode(32'h8040_0000, 7'h60, 8'hFD, 8'h91);
    mode(32'h8040_0000, 7'h68, 8'hC1, 8'hC0);
    mode(32'h8040_0400, 7'h50, 8'hA0, 8'h80);
    mode(32'h8040_0400, 7'h58, 8'hE0, 8'hC0);
    mode(32'h8000_0400, 7'h58, 8'hC1, 8'hC0);
    mode(32'h8000_0400, 7'h40, 8'hFD, 8'h91);
    mode(32'h8008_0000, 7'h58, 8'h9C, 8'h98);
    mode(32'h8000_0000, 7'h58, 8'h9C, 8'h84);
    mode(32'h8004_0000, 7'h5C, 8'hD2, 8'hC0);
    mode(32'h8000_0000, 7'h5C, 8'hD2, 8'h92);
    mode(32'h8004_0000, 7'h42, 8'h90, 8'h80);
    mode(32'h8004_0000, 7'h51, 8'h90, 8'h80);
    $display("t_modes done");
  endtask : t_modes
  task automatic t_dyn;
    apb(1'h1, `L2M_CTRL_ADDR, 32'h8000_0400);
    apb(1'h1, `L2M_CTRL_ADDR, 32'h8000_0000);
    l2m_l1_model_i.send(7'h40);
    @(negedge pclk);
    `CHK("io cleared live", 8'h00, resp & 8'h01)
    apb(1'h1, `L2M_CTRL_ADDR, 32'h8000_0400);
    l2m_l1_model_i.send(7'h40);
    @(negedge pclk);
    `CHK("io set live", 8'h01, resp & 8'h01)
    $display("t_dyn done");
  endtask : t_dyn
  task automatic t_inv;
    logic busy;
    mode(32'h8000_0000, 7'h50, 8'h80, 8'h80);
    apb(1'h1, `L2M_CTRL_ADDR, 32'h0000_0000);
    apb(1'h0, `L2M_STAT_ADDR, 32'h0000_0000);
    `CHK("lines before", 1'h1, rd[15:0] !== 16'h0000)
    apb(1'h1, `L2M_CTRL_ADDR, 32'h0020_0000);
    // busy pulse expected two edges after the request lands
    busy = 1'h0;
    repeat (4)
    begin
      @(negedge pclk);
      busy = busy | invalidate_busy;
    end
    `CHK("busy seen", 1'h1, busy)
    apb(1'h0, `L2M_STAT_ADDR, 32'h0000_0000);
    `CHK("lines after", 16'h0000, rd[15:0])
    apb(1'h1, `L2M_CTRL_ADDR, 32'h0000_0000);
    $display("t_inv done");
  endtask : t_inv
  task automatic t_sleep;
    apb(1'h1, `L2M_CTRL_ADDR, 32'h0010_0000); // set while running, never in nap
    pw(L2M_NAP, 1'h1);
    pw(L2M_RUN, 1'h0);
    pw(L2M_SLEEP, 1'h1);
    apb(1'h1, `L2M_CTRL_ADDR, 32'h0000_0000);
    pw(L2M_SLEEP, 1'h0);
    $display("t_sleep done");
  endtask : t_sleep
  // mid-run reset must clear the whole control word again
  task automatic t_rst;
    apb(1'h1, `L2M_CTRL_ADDR, 32'h8000_0000);
    repeat (2) @(negedge pclk);
    `CHK("enable pin", 1'h1, cache_enable_bit)
    @(posedge pclk);
    presetn <= 1'h0;
    repeat (3) @(posedge pclk);
    presetn <= 1'h1;
    @(negedge pclk);
    `CHK("enable after reset", 1'h0, cache_enable_bit)
    apb(1'h0, `L2M_CTRL_ADDR, 32'h0000_0000);
    `CHK("ctrl after reset", 32'h0000_0000, rd)
    $display("t_rst done");
  endtask : t_rst
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : give_verdict
  // main sequence after ten reset cycles
  initial
  begin
    repeat (10) @(posedge pclk);
    presetn <= 1'h1;
    t_regs;
    t_modes;
    t_dyn;
    t_inv;
    t_sleep;
    t_rst;
    give_verdict;
  end
  // watchdog, far beyond the few hundred cycles the tests need
  initial
  begin
    #200000;
    error_cnt++;
    give_verdict;
  end
endmodule : l2_cache_mode_control_fields_bench
